// ==== dpr_pkg.sv ====
// dscp remap slice package: register map, field layout, carriers, decoders
// assumes a byte-wide management register space with 16-bit addresses
package dpr_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int ADDR_W    = 16;        // management address width
    localparam int DATA_W    = 8;         // register width
    localparam int DSCP_W    = 6;         // dscp code width
    localparam int PRIO_W    = 3;         // priority field width
    localparam int IDX_W     = 4;         // register index width
    localparam int MAP_COUNT = 12;        // mapping registers in this slice
    localparam int TABLE_W   = MAP_COUNT * DATA_W;
    localparam int POS_W     = 7;         // bit position inside flat table

    // ------------------------------------------------------------
    // register map and field layout
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] MAP_OFS [MAP_COUNT] = '{
        16'h0345, 16'h0346, 16'h0347, 16'h0348, 16'h0349, 16'h034a,
        16'h034b, 16'h034c, 16'h034d, 16'h034e, 16'h034f, 16'h0350};
    localparam int EVEN_LSB   = 0;        // field of the even code
    localparam int ODD_LSB    = 4;        // field of the odd code
    localparam int CLASS_LSB  = 3;        // dscp class bits 5:3
    localparam int CODE_PAIR  = 2;        // codes held per register
    localparam logic [DATA_W-1:0] MAP_RESET   = 8'h00;
    localparam logic [DATA_W-1:0] MAP_WR_MASK = 8'h77; // bits 7 and 3 reserved
    localparam logic [DSCP_W-1:0] CODE_FIRST  = 6'h0a;
    localparam logic [DSCP_W-1:0] CODE_LAST   = 6'h21;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic              wr;            // write strobe
        logic              rd;            // read strobe
        logic [ADDR_W-1:0] addr;          // register address
        logic [DATA_W-1:0] wdata;         // write data
    } dpr_reg_req_type;
    typedef struct packed {
        logic              valid;         // lookup request
        logic              ip_v6;         // header version, not used for lookup
        logic [DSCP_W-1:0] dscp;          // code of the frame
    } dpr_look_req_type;
    typedef struct packed {
        logic              valid;         // answer strobe
        logic              hit;           // answered from this slice
        logic [PRIO_W-1:0] prio;          // resolved priority
    } dpr_look_res_type;
    typedef struct packed {
        logic             hit;            // address or code is ours
        logic             odd;            // odd code, upper field
        logic [IDX_W-1:0] idx;            // register index
    } dpr_sel_type;

    // address decode, shared by write enables and read mux
    function automatic dpr_sel_type dpr_decode(input logic [ADDR_W-1:0] addr);
        dpr_sel_type d;
        d = '0;
        for (int i = 0; i < MAP_COUNT; i++)
        begin
            if (addr == MAP_OFS[i])
            begin
                d.hit = 1'b1;
                d.idx = IDX_W'(i);
            end
        end
        return d;
    endfunction

    // code decode, used by the lookup path only; the checks write the range out
    function automatic dpr_sel_type dpr_code_sel(input logic [DSCP_W-1:0] dscp);
        dpr_sel_type  d;
        logic [DSCP_W-1:0] rel;
        rel   = dscp - CODE_FIRST;
        d.hit = (dscp >= CODE_FIRST) && (dscp <= CODE_LAST);
        d.odd = dscp[0];
        d.idx = IDX_W'(rel >> 1);
        return d;
    endfunction

endpackage

// ==== dpr_map_entry.sv ====
// one byte-wide mapping register holding an even and an odd priority field
// assumes write strobe and data on the same clock; reset is synchronous
module dpr_map_entry
(
    // clock and reset
    input  wire logic                       clock,
    input  wire logic                       sys_rst,
    // write side
    input  wire logic                       wr_en,
    input  wire logic [dpr_pkg::DATA_W-1:0] wdata,
    // stored value
    output logic      [dpr_pkg::DATA_W-1:0] value
);

    logic [dpr_pkg::DATA_W-1:0] value_reg;  // stored fields

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    // reserved bits are masked on the way in, so they can never read one
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            value_reg <= dpr_pkg::MAP_RESET;
        else if (wr_en)
            value_reg <= wdata & dpr_pkg::MAP_WR_MASK;
    end

    assign value = value_reg;

endmodule // dpr_map_entry

// ==== dpr_lookup.sv ====
// registered dscp to priority resolver over the flat mapping table
// assumes the request comes from logic on the same clock
module dpr_lookup
(
    // clock and reset
    input  wire logic                        clock,
    input  wire logic                        sys_rst,
    // table and mode
    input  wire logic                        remap_en,
    input  wire logic [dpr_pkg::TABLE_W-1:0] table_flat,
    // request and answer
    input  wire dpr_pkg::dpr_look_req_type   look_req,
    output dpr_pkg::dpr_look_res_type        look_res
);

    dpr_pkg::dpr_sel_type            sel;     // slot of the code
    logic [dpr_pkg::POS_W-1:0]       pos;     // field position in table
    logic [dpr_pkg::PRIO_W-1:0]      field;   // mapped priority
    logic                            use_map; // answer from table
    dpr_pkg::dpr_look_res_type       res_reg; // answer register

    // slot selection; version bit deliberately plays no part
    always_comb
    begin
        sel     = dpr_pkg::dpr_code_sel(look_req.dscp);
        pos     = dpr_pkg::POS_W'(sel.idx * dpr_pkg::DATA_W)
                + (sel.odd ? dpr_pkg::POS_W'(dpr_pkg::ODD_LSB) : dpr_pkg::POS_W'(dpr_pkg::EVEN_LSB));
        field   = table_flat[pos +: dpr_pkg::PRIO_W];
        use_map = remap_en && sel.hit;
    end

    // answer one cycle after the request; class bits when remap is off
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            res_reg <= '0;
        else
        begin
            res_reg.valid <= look_req.valid;
            if (look_req.valid)
            begin
                res_reg.hit  <= use_map;
                res_reg.prio <= use_map ? field
                              : look_req.dscp[dpr_pkg::CLASS_LSB +: dpr_pkg::PRIO_W];
            end
        end
    end

    assign look_res = res_reg;

endmodule // dpr_lookup

// ==== dpr_remap_table.sv ====
// dscp remap table slice for codes 0x0a to 0x21: twelve mapping registers,
// their management access port and the lookup used by forwarding
// assumes a single core clock, a synchronous high reset, the global
// remap enable from the neighbouring enable register, and that lookup
// requests come from logic on the same clock
//
// Function
// - codes 0x0a/0x0b map from register 0x0345
// - codes 0x0c/0x0d map from register 0x0346
// - codes 0x0e/0x0f map from register 0x0347
// - codes 0x10/0x11 map from register 0x0348
// - codes 0x12/0x13 map from register 0x0349
// - codes 0x14/0x15 map from register 0x034a
// - codes 0x16/0x17 map from register 0x034b
// - codes 0x18/0x19 map from register 0x034c
// - codes 0x1a/0x1b map from register 0x034d
// - codes 0x1c/0x1d map from register 0x034e
// - codes 0x1e/0x1f map from register 0x034f
// - codes 0x20/0x21 map from register 0x0350
// - fields three bits, read/write, reset zero
// - one table for both ip versions
// - remap off: priority is dscp bits 5:3
module dpr_remap_table
(
    // clock and reset
    input  wire logic                        clock,
    input  wire logic                        sys_rst,
    // management register access
    input  wire dpr_pkg::dpr_reg_req_type    reg_req,
    output logic      [dpr_pkg::DATA_W-1:0]  reg_rdata,
    output logic                             reg_rvalid,
    output logic                             reg_rhit,
    // global remap enable from the enable register
    input  wire logic                        remap_en,
    // forwarding lookup
    input  wire dpr_pkg::dpr_look_req_type   look_req,
    output dpr_pkg::dpr_look_res_type        look_res
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    dpr_pkg::dpr_sel_type             dec;        // address decode
    logic [dpr_pkg::DATA_W-1:0]       map [dpr_pkg::MAP_COUNT]; // register values
    logic [dpr_pkg::TABLE_W-1:0]      table_flat; // flat view for lookup
    logic [dpr_pkg::DATA_W-1:0]       rdata_reg;  // read data
    logic                             rvalid_reg; // read answer strobe
    logic                             rhit_reg;   // read hit one of ours

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    // one decode feeds both the write enables and the read mux
    always_comb
    begin
        dec = dpr_pkg::dpr_decode(reg_req.addr);
    end

    // ------------------------------------------------------------
    // mapping registers
    // ------------------------------------------------------------
    // register g holds codes first+2g (low field) and first+2g+1 (high field);
    // this one placement carries all twelve pairs
    for (genvar g = 0; g < dpr_pkg::MAP_COUNT; g++)
    begin : gen_map
        // write lands only on an exact address match
        dpr_map_entry u_entry
        (
            .clock   (clock),
            .sys_rst (sys_rst),
            .wr_en   (reg_req.wr && dec.hit && (dec.idx == dpr_pkg::IDX_W'(g))),
            .wdata   (reg_req.wdata),  // reserved bits dropped inside
            .value   (map[g])
        );
        // flat table, register g at byte g
        assign table_flat[g*dpr_pkg::DATA_W +: dpr_pkg::DATA_W] = map[g];
    end

    // ------------------------------------------------------------
    // register read
    // ------------------------------------------------------------
    // answer one cycle after the strobe; an address outside this slice
    // answers zero with the hit flag low so an outer mux can pick another
    // slice. a read and write of the same register in one cycle returns
    // the value from before the write.
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            rdata_reg  <= dpr_pkg::MAP_RESET;
            rvalid_reg <= 1'b0;
            rhit_reg   <= 1'b0;
        end
        else
        begin
            rvalid_reg <= reg_req.rd;
            if (reg_req.rd)
            begin
                rhit_reg  <= dec.hit;
                // stored bits 7 and 3 are always zero
                rdata_reg <= dec.hit ? map[dec.idx] : dpr_pkg::MAP_RESET;
            end
        end
    end

    assign reg_rdata  = rdata_reg;
    assign reg_rvalid = rvalid_reg;
    assign reg_rhit   = rhit_reg;

    // ------------------------------------------------------------
    // lookup
    // ------------------------------------------------------------
    // one resolver for both header versions; the version bit is carried
    // only so that upstream need not strip it
    dpr_lookup u_lookup
    (
        .clock      (clock),
        .sys_rst    (sys_rst),
        .remap_en   (remap_en),    // class bits when clear
        .table_flat (table_flat),
        .look_req   (look_req),
        .look_res   (look_res)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    // a mapped lookup of one code
    sequence s_ask(logic [dpr_pkg::DSCP_W-1:0] code);
        look_req.valid && remap_en && (look_req.dscp == code);
    endsequence

    // answer one cycle later, taken from the right field of register k
    property p_pair(int k);
        (s_ask(dpr_pkg::DSCP_W'(dpr_pkg::CODE_FIRST + dpr_pkg::CODE_PAIR*k))
            |=> look_res.valid && look_res.hit
                && (look_res.prio == $past(map[k][dpr_pkg::EVEN_LSB +: dpr_pkg::PRIO_W])))
        and
        (s_ask(dpr_pkg::DSCP_W'(dpr_pkg::CODE_FIRST + dpr_pkg::CODE_PAIR*k + 1))
            |=> look_res.valid && look_res.hit
                && (look_res.prio == $past(map[k][dpr_pkg::ODD_LSB +: dpr_pkg::PRIO_W])));
    endproperty

    a_map_0a_0b: assert property (p_pair(0))
        else $error("codes 0x0a/0x0b answered from wrong field");
    a_map_0c_0d: assert property (p_pair(1))
        else $error("codes 0x0c/0x0d answered from wrong field");
    a_map_0e_0f: assert property (p_pair(2))
        else $error("codes 0x0e/0x0f answered from wrong field");
    a_map_10_11: assert property (p_pair(3))
        else $error("codes 0x10/0x11 answered from wrong field");
    a_map_12_13: assert property (p_pair(4))
        else $error("codes 0x12/0x13 answered from wrong field");
    a_map_14_15: assert property (p_pair(5))
        else $error("codes 0x14/0x15 answered from wrong field");
    a_map_16_17: assert property (p_pair(6))
        else $error("codes 0x16/0x17 answered from wrong field");
    a_map_18_19: assert property (p_pair(7))
        else $error("codes 0x18/0x19 answered from wrong field");
    a_map_1a_1b: assert property (p_pair(8))
        else $error("codes 0x1a/0x1b answered from wrong field");
    a_map_1c_1d: assert property (p_pair(9))
        else $error("codes 0x1c/0x1d answered from wrong field");
    a_map_1e_1f: assert property (p_pair(10))
        else $error("codes 0x1e/0x1f answered from wrong field");
    a_map_20_21: assert property (p_pair(11))
        else $error("codes 0x20/0x21 answered from wrong field");

    // reset clears the fields; checked on registers 0, 5 and 11 with reset itself as the cause
    a_reset_clears: assert property (disable iff (1'b0)
        sys_rst |=> (map[0] == dpr_pkg::MAP_RESET) && (map[5] == dpr_pkg::MAP_RESET)
                    && (map[11] == dpr_pkg::MAP_RESET) && !reg_rvalid && !look_res.valid)
        else $error("mapping fields not cleared by reset");

    // a write is stored, masked, and read back two cycles later
    sequence s_write_then_read;
        reg_req.wr && dec.hit ##1 reg_req.rd && !reg_req.wr
            && (reg_req.addr == $past(reg_req.addr));
    endsequence
    a_write_readback: assert property (
        s_write_then_read |=> reg_rvalid && reg_rhit
            && (reg_rdata == ($past(reg_req.wdata, 2) & dpr_pkg::MAP_WR_MASK)))
        else $error("written field not read back");

    // every read is answered exactly one cycle later
    a_read_answer: assert property (
        reg_req.rd |=> reg_rvalid ##0 (reg_rhit == $past(dec.hit)))
        else $error("read not answered in one cycle");
    a_read_quiet: assert property (!reg_req.rd |=> !reg_rvalid)
        else $error("read answer without a read");

    // unmapped reads answer zero
    a_read_unmapped: assert property (
        reg_req.rd && !dec.hit |=> (reg_rdata == dpr_pkg::MAP_RESET) && !reg_rhit)
        else $error("unmapped read returned data");

    // reserved bits never read as one
    a_reserved_zero: assert property (
        reg_rvalid |-> ((reg_rdata & ~dpr_pkg::MAP_WR_MASK) == dpr_pkg::MAP_RESET))
        else $error("reserved bit read as one");

    // same code, other version, table untouched: same answer
    sequence s_both_versions;
        (look_req.valid && !reg_req.wr)
        ##1 (look_req.valid && (look_req.dscp == $past(look_req.dscp))
             && (look_req.ip_v6 != $past(look_req.ip_v6))
             && (remap_en == $past(remap_en)));
    endsequence
    a_version_blind: assert property (
        s_both_versions |=> look_res.valid && (look_res.prio == $past(look_res.prio)))
        else $error("answer differs between ip versions");

    // remap off: class bits straight through, never a table hit
    a_remap_off: assert property (
        look_req.valid && !remap_en |=> look_res.valid && !look_res.hit
            && (look_res.prio == $past(look_req.dscp[dpr_pkg::CLASS_LSB +: dpr_pkg::PRIO_W])))
        else $error("remap off did not pass class bits");

    // codes outside this slice are not claimed
    // range test written out, since a member pick on a call result is not
    // taken by every tool
    a_out_of_slice: assert property (
        look_req.valid && !((look_req.dscp >= dpr_pkg::CODE_FIRST) && (look_req.dscp <= dpr_pkg::CODE_LAST))
            |=> look_res.valid && !look_res.hit)
        else $error("code outside slice claimed a hit");

    // answer strobe follows the request by one cycle, no more, no less
    a_look_timing: assert property (
        look_req.valid |=> look_res.valid ##1 (look_res.valid == $past(look_req.valid)))
        else $error("lookup answer strobe misplaced");

endmodule // dpr_remap_table

// ==== dpr_remap_table_tb.sv ====
// self-checking bench for the dscp remap table slice: register access, lookup, reset
// assumes the dpr_pkg package and the dpr_remap_table top are compiled first
module dpr_remap_table_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // signals and model state
    // ------------------------------------------------------------
    logic                      clock;      // core clock, 25 ns
    logic                      sys_rst;    // synchronous reset, high
    dpr_pkg::dpr_reg_req_type  reg_req;    // management request
    logic [7:0]                reg_rdata;  // read data
    logic                      reg_rvalid; // read answer strobe
    logic                      reg_rhit;   // read address is ours
    logic                      remap_en;   // global remap enable
    dpr_pkg::dpr_look_req_type look_req;   // lookup request
    dpr_pkg::dpr_look_res_type look_res;   // lookup answer
    int                        err_count;  // mismatches seen
    int                        n_tests;    // comparisons made
    int                        mem [12];   // model of the twelve registers
    logic                      eh;         // expected hit
    logic [2:0]                ep;         // expected priority

    // clock toggles every half period
    always #12.5 clock = ~clock;

    dpr_remap_table dpr_remap_table_i
    (
        .clock      (clock),
        .sys_rst    (sys_rst),
        .reg_req    (reg_req),
        .reg_rdata  (reg_rdata),
        .reg_rvalid (reg_rvalid),
        .reg_rhit   (reg_rhit),
        .remap_en   (remap_en),
        .look_req   (look_req),
        .look_res   (look_res)
    );

    // ------------------------------------------------------------
    // model, compare and bus tasks
    // ------------------------------------------------------------
    // expected lookup answer; codes outside the slice fall back to class bits
    task automatic exp_look(input int code, input int en);
        int k;
        k = (code - 10) / 2;
        if (en != 0 && code >= 10 && code <= 33)
        begin
            eh = 1'b1;
            ep = 3'((code % 2) ? (mem[k] >> 4) : mem[k]);
        end
        else
        begin
            eh = 1'b0;
            ep = 3'(code >> 3);
        end
    endtask

    // reserved bits 7 and 3 are dropped on write
    task automatic model_write(input int addr, input int data);
        if (addr >= 'h345 && addr <= 'h350)
            mem[addr - 'h345] = data & 'h77;
    endtask

    task automatic chk_reg(input logic [7:0] exp_data, input logic exp_hit);
        n_tests++;
        if ({reg_rvalid, reg_rhit, reg_rdata} !== {1'b1, exp_hit, exp_data})
        begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, {reg_rvalid, reg_rhit, reg_rdata},
                     {1'b1, exp_hit, exp_data});
        end
    endtask

    task automatic chk_look(input logic exp_hit, input logic [2:0] exp_prio);
        n_tests++;
        if (look_res !== {1'b1, exp_hit, exp_prio})
        begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, look_res, {1'b1, exp_hit, exp_prio});
        end
    endtask

    // one write strobe, driven on the falling edge
    task automatic do_write(input logic [15:0] addr, input logic [7:0] data);
        @(negedge clock);
        reg_req = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(negedge clock);
        reg_req = '0;
        model_write(int'(addr), int'(data));
    endtask

    // one read strobe; the answer is settled at the next falling edge
    task automatic do_read(input logic [15:0] addr);
        @(negedge clock);
        reg_req = '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
        @(negedge clock);
        reg_req = '0;
    endtask

    // lookups back to back, valid held high; each answer checked one cycle on
    task automatic look_sweep(input int en);
        int pc;
        remap_en = en[0];
        for (int c = 0; c <= 64; c++)
        begin
            @(negedge clock);
            if (c > 0)
            begin
                exp_look(pc, en);
                chk_look(eh, ep); // to
            end
            pc = c;
            look_req = (c < 64) ? {1'b1, 1'($urandom), 6'(c)} : '0;
        end
    endtask

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ------------------------------------------------------------
    // watchdog and main sequence
    // ------------------------------------------------------------
    // bounds the whole run; a hang counts as a mismatch
    initial
    begin
        repeat (20000) @(posedge clock);
        err_count++;
        $display("MISMATCH t=%0t run did not finish", $time);
        complete_run();
    end

    initial
    begin
        clock = 1'b0;
        sys_rst = 1'b1;
        reg_req = '0;
        look_req = '0;
        remap_en = 1'b0;
        err_count = 0;
        n_tests = 0;
        foreach (mem[i]) mem[i] = 0;
        void'($urandom(32'h89230432));
        repeat (3) @(posedge clock);
        @(negedge clock);
        sys_rst = 1'b0;

        // reset values, and writes to neighbouring addresses ignored
        do_write(16'h0344, 8'hff);
        do_write(16'h0351, 8'hff);
        for (int i = 0; i < 12; i++)
        begin
            do_read(16'h0345 + 16'(i));
            chk_reg(8'h00, 1'b1);
        end
        foreach (mem[i]) mem[i] = 0;
        $display("test reset values done");

        // unmapped reads answer zero with no hit
        do_read(16'h0344);
        chk_reg(8'h00, 1'b0);
        do_read(16'h0351);
        chk_reg(8'h00, 1'b0);
        $display("test unmapped reads done");

        // 0xff in register 0 and random fields in registers 1 to 11, reserved bits set on purpose
        for (int i = 0; i < 12; i++)
            do_write(16'h0345 + 16'(i), (i == 0) ? 8'hff : 8'($urandom) | 8'h88);
        for (int i = 0; i < 12; i++)
        begin
            do_read(16'h0345 + 16'(i));
            chk_reg(8'(mem[i]), 1'b1);
        end
        // write then read back in the very next cycle
        @(negedge clock);
        reg_req = '{wr: 1'b1, rd: 1'b0, addr: 16'h0345, wdata: 8'hff};
        @(negedge clock);
        reg_req = '{wr: 1'b0, rd: 1'b1, addr: 16'h0345, wdata: 8'h00};
        model_write('h345, 'hff);
        @(negedge clock);
        reg_req = '0;
        chk_reg(8'(mem[0]), 1'b1);
        $display("test register readback done");

        // every code with the table on, then off
        look_sweep(1);
        look_sweep(0);
        $display("test lookup sweep done");

        // read, write and lookup in one cycle all see the old value
        @(negedge clock);
        remap_en = 1'b1;
        reg_req = '{wr: 1'b1, rd: 1'b1, addr: 16'h0350, wdata: 8'h5a};
        look_req = '{valid: 1'b1, ip_v6: 1'b1, dscp: 6'h21};
        @(negedge clock);
        reg_req = '0;
        look_req = '{valid: 1'b1, ip_v6: 1'b0, dscp: 6'h21};
        chk_reg(8'(mem[11]), 1'b1);
        exp_look(33, 1);
        chk_look(eh, ep);
        model_write('h350, 'h5a);
        @(negedge clock);
        look_req = '{valid: 1'b1, ip_v6: 1'b1, dscp: 6'h21};
        exp_look(33, 1);
        chk_look(eh, ep);
        @(negedge clock);
        look_req = '0;
        exp_look(33, 1);
        chk_look(eh, ep);
        $display("test same cycle access done");

        // reset in mid run clears every field
        @(negedge clock);
        sys_rst = 1'b1;
        repeat (2) @(negedge clock);
        sys_rst = 1'b0;
        for (int i = 0; i < 12; i++)
        begin
            do_read(16'h0345 + 16'(i));
            chk_reg(8'h00, 1'b1);
        end
        foreach (mem[i]) mem[i] = 0;
        look_sweep(1);
        $display("test mid run reset done");
        complete_run();
    end

endmodule // dpr_remap_table_tb
